//--- hdl/prot_defs.svh
// Offsets, fields, command bytes and timing counts of the sector guard host
`ifndef PROT_DEFS_SVH
`define PROT_DEFS_SVH

`define REG_CMD 8'h00
`define REG_SECTOR 8'h04
`define REG_PWD 8'h08
`define REG_STATUS 8'h0c

`define ST_BUSY 0
`define ST_DONE 1
`define ST_BIT0 2
`define ST_BIT1 3
`define ST_FAIL 4
`define ST_REFUSED 5
`define ST_EXIT 6
`define PWD_IDX_LSB 16

`define ADDR_UNLOCK1 22'h000555
`define ADDR_UNLOCK2 22'h0002aa
`define DATA_UNLOCK1 8'haa
`define DATA_UNLOCK2 8'h55
`define CMD_VOL 8'h48
`define CMD_STAT 8'h58
`define CMD_NV 8'h60
`define CMD_PW 8'h28
`define DATA_PROG1 8'h68
`define DATA_PROG2 8'h48
`define DATA_ERASE1 8'h60
`define DATA_ERASE2 8'h40
`define DATA_RESET 8'hf0
`define CMD_EXIT 8'h90
`define DATA_EXIT 8'h00

`define SECTOR_LSB 12
`define GUARD_PROG_OFS 7'h3a
`define GUARD_ERASE_OFS 7'h7a
`define PW_LOCK_OFS 6'h0a
`define PS_LOCK_OFS 6'h12

`define CLK_MHZ 50
`define PROG_WAIT_US 100
`define ERASE_WAIT_US 1200
`define PW_GAP_US 2
`define PW_GAP_CYC (`PW_GAP_US * `CLK_MHZ)

`define WR_PULSE_CYC 4'h4
`define RD_PULSE_CYC 4'h8
`define HOLD_CYC 4'h2
`define MAX_RETRY 2'h3

`endif

//--- hdl/prot_pkg.sv
// Types shared by the sector guard host modules
package prot_pkg;
  typedef enum logic [3:0] {
    OP_VOL_SET = 4'h1, OP_VOL_CLR = 4'h2, OP_VOL_STAT = 4'h3, OP_LOCK_STAT = 4'h4,
    OP_PPB_PROG = 4'h5, OP_PPB_ERASE = 4'h6, OP_PWL_PROG = 4'h7, OP_PSL_PROG = 4'h8,
    OP_PWL_STAT = 4'h9, OP_PSL_STAT = 4'ha, OP_PW_PORTION = 4'hb, OP_EXIT = 4'hc,
    OP_RESET = 4'hd
  } op_t;
  typedef enum logic [1:0] {K_WR, K_RD, K_WAIT, K_END} step_kind_t;
  typedef enum logic [1:0] {W_PROG, W_ERASE, W_PW} wait_sel_t;
  typedef struct packed {
    step_kind_t kind;
    wait_sel_t wsel;
    logic [21:0] addr;
    logic [15:0] data;
  } step_t;
  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] dq_o;
    logic dq_drive_n;
    logic ce_n;
    logic we_n;
    logic rd_n;
  } flash_out_t;
endpackage

//--- hdl/wait_timer.sv
// Down counter that times the pauses between bus cycles
`timescale 1ns/1ps
module wait_timer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire logic [16:0] count,
  output logic done
);
  logic [16:0] cnt_q;
  logic busy_q;
  logic done_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 17'h00000;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (load) begin
        cnt_q <= (count == 17'h00000) ? 17'h00001 : count;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        cnt_q <= cnt_q - 17'h00001;
        if (cnt_q == 17'h00001) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign done = done_q;
endmodule // wait_timer

//--- hdl/flash_cycle.sv
// One write or read cycle on the flash pins, strobe timing included
`timescale 1ns/1ps
`include "prot_defs.svh"
module flash_cycle import prot_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic is_read,
  input wire logic [21:0] addr,
  input wire logic [15:0] data,
  input wire logic [15:0] dq_i,
  output flash_out_t pins,
  output logic done,
  output logic [15:0] rd_data
);
  typedef enum logic [1:0] {C_IDLE, C_SETUP, C_PULSE, C_HOLD} cyc_state_t;
  cyc_state_t st_q;
  flash_out_t pins_q;
  logic [3:0] cnt_q;
  logic rd_q;
  logic done_q;
  logic [15:0] dq_s1_q;
  logic [15:0] dq_s2_q;
  logic [15:0] rd_data_q;

  // Pins are asynchronous to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
    end else begin
      dq_s1_q <= dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= C_IDLE;
      pins_q <= '{addr: 22'h000000, dq_o: 16'h0000, dq_drive_n: 1'b1, ce_n: 1'b1,
                  we_n: 1'b1, rd_n: 1'b1};
      cnt_q <= 4'h0;
      rd_q <= 1'b0;
      done_q <= 1'b0;
      rd_data_q <= 16'h0000;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        C_IDLE: if (start) begin
          pins_q.addr <= addr;
          pins_q.dq_o <= data;
          pins_q.dq_drive_n <= is_read;
          pins_q.ce_n <= 1'b0;
          rd_q <= is_read;
          st_q <= C_SETUP;
        end
        C_SETUP: begin
          pins_q.we_n <= rd_q;
          pins_q.rd_n <= !rd_q;
          cnt_q <= (rd_q ? `RD_PULSE_CYC : `WR_PULSE_CYC) - 4'h1;
          st_q <= C_PULSE;
        end
        C_PULSE: if (cnt_q == 4'h0) begin
          // Read pulse covers access time plus the two sync stages
          if (rd_q) rd_data_q <= dq_s2_q;
          pins_q.we_n <= 1'b1;
          pins_q.rd_n <= 1'b1;
          cnt_q <= `HOLD_CYC - 4'h1;
          st_q <= C_HOLD;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
        C_HOLD: if (cnt_q == 4'h0) begin
          pins_q.ce_n <= 1'b1;
          pins_q.dq_drive_n <= 1'b1;
          done_q <= 1'b1;
          st_q <= C_IDLE;
        end else begin
          cnt_q <= cnt_q - 4'h1;
        end
        default: st_q <= C_IDLE;
      endcase
    end
  end

  assign pins = pins_q;
  assign done = done_q;
  assign rd_data = rd_data_q;

  property p_we_latch;
    @(posedge pclk) disable iff (!presetn)
    $rose(pins_q.we_n) |-> !pins_q.dq_drive_n && !pins_q.ce_n && $stable(pins_q.dq_o)
      && $stable(pins_q.addr);
  endproperty
  a_we_latch: assert property (p_we_latch) else $error("data moved at write strobe rise");
endmodule // flash_cycle

//--- hdl/sector_guard_host.sv
// APB-controlled host that runs sector protection command sequences on a flash
//
// Implementation choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "prot_defs.svh"
module sector_guard_host import prot_pkg::*; #(
  parameter int PROG_WAIT_CYC = `PROG_WAIT_US * `CLK_MHZ,
  parameter int ERASE_WAIT_CYC = `ERASE_WAIT_US * `CLK_MHZ
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output flash_out_t flash,
  input wire logic [15:0] flash_dq_i
);
  typedef enum logic [1:0] {S_IDLE, S_STEP, S_BUS, S_WAIT} seq_state_t;

  function automatic logic is_prog(op_t op);
    return op == OP_PPB_PROG || op == OP_PPB_ERASE || op == OP_PWL_PROG || op == OP_PSL_PROG;
  endfunction

  function automatic logic is_stat(op_t op);
    return op == OP_VOL_STAT || op == OP_LOCK_STAT || op == OP_PWL_STAT || op == OP_PSL_STAT;
  endfunction

  function automatic step_t step_of(op_t op, logic [2:0] idx, logic [9:0] sec,
                                    logic [15:0] pwv, logic [1:0] pwi);
    step_t s;
    logic [21:0] sa;
    logic [21:0] tgt;
    logic [21:0] vaddr;
    logic [7:0] c3;
    logic [7:0] d4;
    logic [15:0] d3;
    s = '{kind: K_END, wsel: W_PROG, addr: 22'h000000, data: 16'h0000};
    sa = {sec, 12'h000};
    tgt = sa;
    c3 = `CMD_NV;
    d4 = `DATA_PROG1;
    d3 = 16'h0000;
    case (op)
      OP_VOL_SET, OP_VOL_CLR: begin
        c3 = `CMD_VOL;
        d3 = {15'h0000, op == OP_VOL_SET};
      end
      OP_VOL_STAT, OP_LOCK_STAT: c3 = `CMD_STAT;
      OP_PPB_PROG: tgt = sa | {15'h0000, `GUARD_PROG_OFS};
      OP_PPB_ERASE: begin
        tgt = sa | {15'h0000, `GUARD_ERASE_OFS};
        d4 = `DATA_ERASE1;
      end
      OP_PWL_PROG, OP_PWL_STAT: tgt = {16'h0000, `PW_LOCK_OFS};
      OP_PSL_PROG, OP_PSL_STAT: tgt = {16'h0000, `PS_LOCK_OFS};
      OP_PW_PORTION: begin
        c3 = `CMD_PW;
        tgt = {20'h00000, pwi};
        d3 = pwv;
      end
      OP_EXIT: begin
        c3 = `CMD_EXIT;
        tgt = 22'h000000;
        d3 = {8'h00, `DATA_EXIT};
      end
      default: c3 = `CMD_NV;
    endcase
    vaddr = (op == OP_PPB_ERASE) ? (sa | {15'h0000, `GUARD_PROG_OFS}) : tgt;
    if (op == OP_RESET) begin
      if (idx == 3'h0) s = '{K_WR, W_PROG, 22'h000000, {8'h00, `DATA_RESET}};
    end else begin
      // Every command except OP_RESET, each password portion too, starts with both unlock writes
      case (idx)
        3'h0: s = '{K_WR, W_PROG, `ADDR_UNLOCK1, {8'h00, `DATA_UNLOCK1}};
        3'h1: s = '{K_WR, W_PROG, `ADDR_UNLOCK2, {8'h00, `DATA_UNLOCK2}};
        3'h2: s = '{K_WR, W_PROG, `ADDR_UNLOCK1, {8'h00, c3}};
        3'h3: begin
          if (is_stat(op)) s = '{K_RD, W_PROG, tgt, 16'h0000};
          else if (is_prog(op)) s = '{K_WR, W_PROG, tgt, {8'h00, d4}};
          else s = '{K_WR, W_PROG, tgt, d3};
        end
        3'h4: begin
          if (op == OP_PPB_ERASE) s.kind = K_WAIT;
          else if (is_prog(op)) s.kind = K_WAIT;
          else if (op == OP_PW_PORTION) s.kind = K_WAIT;
          s.wsel = (op == OP_PPB_ERASE) ? W_ERASE : (op == OP_PW_PORTION) ? W_PW : W_PROG;
        end
        3'h5: if (is_prog(op)) s = '{K_WR, W_PROG, vaddr,
            {8'h00, (op == OP_PPB_ERASE) ? `DATA_ERASE2 : `DATA_PROG2}};
        3'h6: if (is_prog(op)) s = '{K_RD, W_PROG, vaddr, 16'h0000};
        default: s.kind = K_END;
      endcase
    end
    return s;
  endfunction

  seq_state_t state_q, state_d;
  op_t op_q;
  logic [9:0] sector_q;
  logic [15:0] pwv_q;
  logic [1:0] pwi_q;
  logic [2:0] idx_q, idx_d;
  logic [1:0] retry_q, retry_d;
  logic bit0_q, bit1_q, done_q, fail_q, refused_q, exit_need_q;
  logic [16:0] gap_q;
  step_t cur;
  logic cyc_start, cyc_done, tmr_load, tmr_done, finish;
  logic [15:0] cyc_rd;
  logic [16:0] tmr_count;

  // APB slave: always ready, error on unmapped offsets
  wire wr_acc = psel & penable & pwrite;
  wire sel_cmd = paddr == `REG_CMD;
  wire sel_sec = paddr == `REG_SECTOR;
  wire sel_pwd = paddr == `REG_PWD;
  wire sel_st = paddr == `REG_STATUS;
  wire hit = sel_cmd | sel_sec | sel_pwd | sel_st;
  wire idle = state_q == S_IDLE;
  wire op_ok = pwdata[3:0] >= OP_VOL_SET && pwdata[3:0] <= OP_RESET;
  wire op_t op_in = op_t'(pwdata[3:0]);
  // Guard program/erase/verify is held off after OP_LOCK_STAT or OP_PW_PORTION until the exit command has run
  wire blocked = exit_need_q && (op_in == OP_PPB_PROG || op_in == OP_PPB_ERASE);
  wire cmd_go = wr_acc & sel_cmd & idle & op_ok & !blocked;
  wire cmd_bad = wr_acc & sel_cmd & !cmd_go;
  wire [31:0] status = {25'h0, exit_need_q, refused_q, fail_q, bit1_q, bit0_q, done_q, !idle};

  assign pready = 1'b1;
  assign pslverr = psel & penable & !hit;
  assign prdata = sel_cmd ? {28'h0, op_q} :
                  sel_sec ? {22'h0, sector_q} :
                  sel_pwd ? {14'h0, pwi_q, pwv_q} :
                  sel_st ? status : 32'h0;

  assign cur = step_of(op_q, idx_q, sector_q, pwv_q, pwi_q);
  // Program expects bit 0 set, erase expects it clear
  wire verify_bad = (op_q == OP_PPB_ERASE) ? bit0_q : !bit0_q;
  wire retry_ok = is_prog(op_q) && verify_bad && retry_q != `MAX_RETRY;
  assign tmr_count = (cur.wsel == W_ERASE) ? 17'(ERASE_WAIT_CYC) :
                     (cur.wsel == W_PW) ? 17'(`PW_GAP_CYC) : 17'(PROG_WAIT_CYC);

  always_comb begin
    state_d = state_q;
    idx_d = idx_q;
    retry_d = retry_q;
    cyc_start = 1'b0;
    tmr_load = 1'b0;
    finish = 1'b0;
    case (state_q)
      S_IDLE: if (cmd_go) begin
        state_d = S_STEP;
        idx_d = 3'h0;
        retry_d = 2'h0;
      end
      S_STEP: case (cur.kind)
        K_WR, K_RD: begin
          cyc_start = 1'b1;
          state_d = S_BUS;
        end
        K_WAIT: begin
          tmr_load = 1'b1;
          state_d = S_WAIT;
        end
        default: if (retry_ok) begin
          idx_d = 3'h0;
          retry_d = retry_q + 2'h1;
        end else begin
          finish = 1'b1;
          state_d = S_IDLE;
        end
      endcase
      S_BUS: if (cyc_done) begin
        idx_d = idx_q + 3'h1;
        state_d = S_STEP;
      end
      S_WAIT: if (tmr_done) begin
        idx_d = idx_q + 3'h1;
        state_d = S_STEP;
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_IDLE;
      idx_q <= 3'h0;
      retry_q <= 2'h0;
    end else begin
      state_q <= state_d;
      idx_q <= idx_d;
      retry_q <= retry_d;
    end
  end

  // Parameters are frozen while a sequence runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_q <= OP_RESET;
      sector_q <= 10'h000;
      pwv_q <= 16'h0000;
      pwi_q <= 2'h0;
    end else if (wr_acc && idle) begin
      if (cmd_go) op_q <= op_in;
      if (sel_sec) sector_q <= pwdata[9:0];
      if (sel_pwd) {pwi_q, pwv_q} <= pwdata[`PWD_IDX_LSB+1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit0_q <= 1'b0;
      bit1_q <= 1'b0;
    end else if (cyc_done && cur.kind == K_RD) begin
      bit0_q <= cyc_rd[0];
      bit1_q <= cyc_rd[1];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      refused_q <= 1'b0;
      exit_need_q <= 1'b0;
    end else begin
      if (cmd_go) done_q <= 1'b0;
      else if (finish) done_q <= 1'b1;
      if (cmd_go) fail_q <= 1'b0;
      else if (finish) fail_q <= is_prog(op_q) && verify_bad;
      if (cmd_bad) refused_q <= 1'b1;
      else if (cmd_go) refused_q <= 1'b0;
      if (finish && (op_q == OP_LOCK_STAT || op_q == OP_PW_PORTION)) exit_need_q <= 1'b1;
      else if (finish && op_q == OP_EXIT) exit_need_q <= 1'b0;
    end
  end

  // Erase-all does not check that every guard was programmed first
  flash_cycle u_cycle (
    .pclk(pclk),
    .presetn(presetn),
    .start(cyc_start),
    .is_read(cur.kind == K_RD),
    .addr(cur.addr),
    .data(cur.data),
    .dq_i(flash_dq_i),
    .pins(flash),
    .done(cyc_done),
    .rd_data(cyc_rd)
  );

  wait_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // Cycles since the last bus cycle ended, for the spacing checks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) gap_q <= 17'h00000;
    else if (cyc_done) gap_q <= 17'h00000;
    else if (gap_q != 17'h1ffff) gap_q <= gap_q + 17'h00001;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_unlock1;
    cyc_start && idx_q == 3'h0 && op_q != OP_RESET |->
      cur.addr[11:0] == `ADDR_UNLOCK1 && cur.data[7:0] == `DATA_UNLOCK1;
  endproperty
  a_unlock1: assert property (p_unlock1) else $error("first unlock write wrong");

  property p_unlock2;
    cyc_done && idx_q == 3'h0 && op_q != OP_RESET |=>
      cyc_start && cur.addr[11:0] == `ADDR_UNLOCK2 && cur.data[7:0] == `DATA_UNLOCK2;
  endproperty
  a_unlock2: assert property (p_unlock2) else $error("second unlock write wrong");

  property p_ppb_addr;
    cyc_start && op_q == OP_PPB_PROG && idx_q >= 3'h3 |->
      cur.addr[6:0] == `GUARD_PROG_OFS && cur.addr[21:12] == sector_q;
  endproperty
  a_ppb_addr: assert property (p_ppb_addr) else $error("guard program address wrong");

  property p_erase_addr;
    cyc_start && op_q == OP_PPB_ERASE && idx_q == 3'h3 |->
      cur.addr[6:0] == `GUARD_ERASE_OFS && cur.data[7:0] == `DATA_ERASE1;
  endproperty
  a_erase_addr: assert property (p_erase_addr) else $error("erase address wrong");

  property p_pwl_addr;
    cyc_start && (op_q == OP_PWL_PROG || op_q == OP_PWL_STAT) && idx_q >= 3'h3 |->
      cur.addr[5:0] == `PW_LOCK_OFS;
  endproperty
  a_pwl_addr: assert property (p_pwl_addr) else $error("password lock address wrong");

  property p_psl_addr;
    cyc_start && (op_q == OP_PSL_PROG || op_q == OP_PSL_STAT) && idx_q >= 3'h3 |->
      cur.addr[5:0] == `PS_LOCK_OFS;
  endproperty
  a_psl_addr: assert property (p_psl_addr) else $error("persistent lock address wrong");

  property p_prog_gap;
    cyc_start && idx_q == 3'h5 && op_q != OP_PPB_ERASE |-> gap_q >= 17'(PROG_WAIT_CYC);
  endproperty
  a_prog_gap: assert property (p_prog_gap) else $error("program pause too short");

  property p_erase_gap;
    cyc_start && idx_q == 3'h5 && op_q == OP_PPB_ERASE |-> gap_q >= 17'(ERASE_WAIT_CYC);
  endproperty
  a_erase_gap: assert property (p_erase_gap) else $error("erase pause too short");

  property p_pw_gap;
    finish && op_q == OP_PW_PORTION |-> gap_q >= 17'(`PW_GAP_CYC);
  endproperty
  a_pw_gap: assert property (p_pw_gap) else $error("password portions too close");

  property p_retry;
    state_q == S_STEP && cur.kind == K_END && retry_ok |=> idx_q == 3'h0 ##0 cyc_start;
  endproperty
  a_retry: assert property (p_retry) else $error("failed verify not reissued");

  property p_exit;
    $rose(state_q != S_IDLE) && (op_q == OP_PPB_PROG || op_q == OP_PPB_ERASE) |->
      !$past(exit_need_q);
  endproperty
  a_exit: assert property (p_exit) else $error("guard touched before exit");

  c_prog_pass: cover property (finish && op_q == OP_PPB_PROG && !verify_bad);
  c_erase_retry: cover property (retry_ok && op_q == OP_PPB_ERASE && cur.kind == K_END);
  c_pw: cover property (finish && op_q == OP_PW_PORTION);
  c_refused: cover property (cmd_bad);
endmodule // sector_guard_host

//--- tb/flash_guard_model.sv
// Behavioural flash that answers the sector guard command sequences
`timescale 1ns/1ps
module flash_guard_model import prot_pkg::*; #(
  parameter real PROG_NS = 1000.0,
  parameter real ERASE_NS = 1600.0,
  parameter real GAP_NS = 2000.0
) (
  input wire flash_out_t flash,
  input wire logic verify_ok,
  output logic [15:0] dq,
  output int prog_cnt,
  output int proto_err,
  output logic [3:0] pw_seen
);
  logic [1023:0] vol_q = '0;
  logic pwl_q = 1'b0;
  logic psl_q = 1'b0;
  logic ver_q = 1'b0;
  logic [1:0] mode_q = 2'h0;
  logic [7:0] cmd_q = 8'h00;
  logic [21:0] tgt_q = 22'h0;
  logic [15:0] rd_w;
  logic [15:0] last_q = 16'h0;
  int idx = 0;
  realtime t4 = 0.0;
  realtime t_pw = -1.0e9;
  wire [21:0] a = flash.addr;
  wire [7:0] d = flash.dq_o[7:0];
  wire unlock1 = a[10:0] == 11'h555 && d == 8'haa;
  initial begin
    prog_cnt = 0;
    proto_err = 0;
    pw_seen = 4'h0;
  end
  always_comb begin
    case (mode_q)
      2'h1: rd_w = {15'h0, vol_q[a[21:12]]};
      2'h2: rd_w = {15'h0, a[5:0] == 6'h0a ? pwl_q : psl_q};
      2'h3: rd_w = {15'h0, ver_q};
      default: rd_w = 16'hffff;
    endcase
  end
  // Released bus shows the inverse, so a stale sample cannot pass
  assign dq = (!flash.ce_n && !flash.rd_n) ? rd_w : ~last_q;
  // A status read is the last cycle of its command
  always @(posedge flash.rd_n) begin
    last_q = rd_w;
    if (idx == 3) idx = 0;
  end
  always @(posedge flash.we_n) if (!flash.ce_n) begin
    if (d == 8'hf0 && !(idx == 3 && cmd_q == 8'h28)) begin
      idx = 0;
      mode_q = 2'h0;
    end else begin
      case (idx)
        0: idx = unlock1;
        1: idx = (a[10:0] == 11'h2aa && d == 8'h55) ? 2 : int'(unlock1);
        2: begin
          cmd_q = d;
          idx = 3;
          mode_q = d == 8'h58 ? 2'h1 : d == 8'h60 ? 2'h2 : 2'h0;
        end
        3: begin
          idx = 0;
          mode_q = 2'h0;
          tgt_q = a;
          if (cmd_q == 8'h48) vol_q[a[21:12]] = flash.dq_o[0];
          else if (cmd_q == 8'h28) begin
            if (a[21:2] != 20'h0 || $realtime - t_pw < GAP_NS) proto_err++;
            pw_seen[a[1:0]] = 1'b1;
            t_pw = $realtime;
          end else if (cmd_q == 8'h60 && ((d == 8'h68 && (a[6:0] == 7'h3a ||
              a[5:0] == 6'h0a || a[5:0] == 6'h12)) || (d == 8'h60 && a[6:0] == 7'h7a))) begin
            idx = 4;
            t4 = $realtime;
          end
        end
        default: begin
          idx = 0;
          mode_q = 2'h3;
          if (d == 8'h48) begin
            prog_cnt++;
            if ($realtime - t4 < PROG_NS) proto_err++;
            ver_q = verify_ok;
            if (verify_ok && tgt_q[5:0] == 6'h0a) pwl_q = 1'b1;
            if (verify_ok && tgt_q[5:0] == 6'h12) psl_q = 1'b1;
          end else if (d == 8'h40) begin
            if ($realtime - t4 < ERASE_NS) proto_err++;
            ver_q = !verify_ok;
          end else mode_q = 2'h0;
        end
      endcase
    end
  end
endmodule // flash_guard_model

//--- tb/sector_guard_host_tb.sv
// Self-checking bench of the sector guard host against a flash model
`timescale 1ns/1ps
`include "prot_defs.svh"
module sector_guard_host_tb import prot_pkg::*; ;
  typedef struct packed {
    op_t op;
    logic [9:0] sec;
    logic [17:0] pw;
    logic [6:0] mask;
    logic [6:0] val;
  } row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, verify_ok, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, st;
  logic [15:0] dq;
  logic [3:0] pw_seen;
  flash_out_t flash;
  int prog_cnt, proto_err, n0;
  int err_count = 0;
  int checks = 0;
  row_t rows [20];
  sector_guard_host #(.PROG_WAIT_CYC(50), .ERASE_WAIT_CYC(80)) sector_guard_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash(flash), .flash_dq_i(dq));
  flash_guard_model #(.PROG_NS(1000.0), .ERASE_NS(1600.0), .GAP_NS(`PW_GAP_CYC * 20.0))
    flash_guard_model_i (.flash(flash), .verify_ok(verify_ok), .dq(dq),
    .prog_cnt(prog_cnt), .proto_err(proto_err), .pw_seen(pw_seen));
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
      output logic [31:0] rd, output logic err);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, wd, r, x);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic x;
    apb(1'b0, a, 32'h0, r, x);
  endtask
  task automatic run_op(input op_t op, input logic [9:0] sec, input logic [17:0] pw);
    int n;
    wr(`REG_SECTOR, {22'h0, sec});
    wr(`REG_PWD, {14'h0, pw});
    wr(`REG_CMD, {28'h0, op});
    n = 0;
    do begin
      rd(`REG_STATUS, st);
      n++;
    end while (st[`ST_BUSY] !== 1'b0 && n < 1000);
    if (st[`ST_BUSY] !== 1'b0) begin
      err_count++;
      summarize();
    end
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    verify_ok = 1'b1;
    presetn = 1'b0;
    rows = '{
      '{OP_VOL_SET, 10'h5, 18'h0, 7'h10, 7'h00}, '{OP_VOL_STAT, 10'h5, 18'h0, 7'h04, 7'h04},
      '{OP_VOL_STAT, 10'h6, 18'h0, 7'h04, 7'h00}, '{OP_VOL_CLR, 10'h5, 18'h0, 7'h10, 7'h00},
      '{OP_VOL_STAT, 10'h5, 18'h0, 7'h04, 7'h00}, '{OP_PPB_PROG, 10'h3, 18'h0, 7'h10, 7'h00},
      '{OP_PPB_ERASE, 10'h3, 18'h0, 7'h10, 7'h00}, '{OP_PWL_PROG, 10'h0, 18'h0, 7'h10, 7'h00},
      '{OP_PWL_STAT, 10'h0, 18'h0, 7'h04, 7'h04}, '{OP_PSL_STAT, 10'h0, 18'h0, 7'h04, 7'h00},
      '{OP_PSL_PROG, 10'h0, 18'h0, 7'h10, 7'h00}, '{OP_PSL_STAT, 10'h0, 18'h0, 7'h04, 7'h04},
      '{OP_LOCK_STAT, 10'h2, 18'h0, 7'h48, 7'h40}, '{OP_PPB_PROG, 10'h3, 18'h0, 7'h20, 7'h20},
      '{OP_EXIT, 10'h0, 18'h0, 7'h40, 7'h00}, '{OP_PW_PORTION, 10'h0, 18'h01234, 7'h40, 7'h40},
      '{OP_PW_PORTION, 10'h0, 18'h1abcd, 7'h40, 7'h40},
      '{OP_PW_PORTION, 10'h0, 18'h2f0f0, 7'h40, 7'h40},
      '{OP_PW_PORTION, 10'h0, 18'h3ffff, 7'h40, 7'h40},
      '{OP_PPB_PROG, 10'h3, 18'h0, 7'h20, 7'h20}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`REG_CMD, st);
    chk("op after reset", 32'hd, st);
    chk("pins after reset", 4'hf, {flash.ce_n, flash.we_n, flash.rd_n, flash.dq_drive_n});
    foreach (rows[i]) begin
      run_op(rows[i].op, rows[i].sec, rows[i].pw);
      chk($sformatf("status row %0d", i), rows[i].val, st[6:0] & rows[i].mask);
    end
    run_op(OP_EXIT, 10'h0, 18'h0);
    verify_ok <= 1'b0;
    n0 = prog_cnt;
    run_op(OP_PPB_PROG, 10'h3, 18'h0);
    chk("program fail", 1'b1, st[`ST_FAIL]);
    chk("program attempts", 32'h4, prog_cnt - n0);
    run_op(OP_PPB_ERASE, 10'h3, 18'h0);
    chk("erase fail", 1'b1, st[`ST_FAIL]);
    verify_ok <= 1'b1;
    wr(`REG_SECTOR, 32'h7);
    wr(`REG_CMD, {28'h0, OP_VOL_SET});
    run_op(OP_VOL_CLR, 10'h7, 18'h0);
    chk("busy refusal", 1'b1, st[`ST_REFUSED]);
    run_op(OP_VOL_STAT, 10'h7, 18'h0);
    chk("set kept", 1'b1, st[`ST_BIT0]);
    wr(`REG_CMD, 32'he);
    rd(`REG_STATUS, st);
    chk("bad opcode", 1'b1, st[`ST_REFUSED]);
    apb(1'b0, 8'h10, 32'h0, st, e);
    chk("unmapped error", 1'b1, e);
    chk("unmapped data", 32'h0, st);
    // Reset lands inside a sequence, so the flash is left mid-command
    wr(`REG_CMD, {28'h0, OP_PPB_PROG});
    repeat (30) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("pins in reset", 4'hf, {flash.ce_n, flash.we_n, flash.rd_n, flash.dq_drive_n});
    presetn <= 1'b1;
    rd(`REG_STATUS, st);
    chk("status after reset", 32'h0, st);
    run_op(OP_RESET, 10'h0, 18'h0);
    run_op(OP_VOL_STAT, 10'h7, 18'h0);
    chk("recovered status", 1'b1, st[`ST_BIT0]);
    chk("flash protocol", 32'h0, proto_err);
    chk("portions seen", 4'hf, pw_seen);
    summarize();
  end
endmodule // sector_guard_host_tb
